// *** include/sifc_pkg.sv ***
// Purpose : constants for the sensor filter / pin / converter configuration block
// Assumes : 10 MHz clock, byte-wide register writes carried in 16-bit command words
// Notes   : command word [15] write flag, [14:8] byte address, [7:0] data
//
// Operation
// - two cascaded averaging stages, 2^field taps each
// - tap field 100 gives sixteen taps
// - range field 100/010/001 selects 300/150/75
// - 150 range forces taps>=4, 75 forces >=16
// - pin priority: misc, then alarm, then direction
// - direction bit one makes pin an output
// - level bits 8..11 drive pins one..four
// - pin four clocks sampling when input, period zero
// - reset default: active-high ready on pin one
// - ready enable, polarity, pin select bits 2..0
// - ready pulse lasts 100 to 200 us
// - test start bits clear when routine completes
// - bits 9/8 apply negative/positive stimulus
// - bits 7/6 enable bias compensation, origin alignment
// - converter code is 12-bit offset binary
// - converter output updates only on latch command
package sifc_pkg;

  // ****************************************
  // byte addresses (low byte even)
  // ****************************************
  localparam logic [6:0] ADDR_AUX_LO  = 7'h30;
  localparam logic [6:0] ADDR_AUX_HI  = 7'h31;
  localparam logic [6:0] ADDR_PIN_LO  = 7'h32;
  localparam logic [6:0] ADDR_PIN_HI  = 7'h33;
  localparam logic [6:0] ADDR_MISC_LO = 7'h34;
  localparam logic [6:0] ADDR_MISC_HI = 7'h35;
  localparam logic [6:0] ADDR_PRD_LO  = 7'h36;
  localparam logic [6:0] ADDR_PRD_HI  = 7'h37;
  localparam logic [6:0] ADDR_FILT_LO = 7'h38;
  localparam logic [6:0] ADDR_FILT_HI = 7'h39;
  localparam logic [6:0] ADDR_GCMD_LO = 7'h3e;

  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [15:0] RST_FILT = 16'h0402;
  localparam logic [15:0] RST_PIN  = 16'h0000;
  localparam logic [15:0] RST_MISC = 16'h0006;
  localparam logic [15:0] RST_AUX  = 16'h0000;
  localparam logic [15:0] RST_PRD  = 16'h0001;
  localparam logic [15:0] MSK_FILT = 16'h0707;
  localparam logic [15:0] MSK_PIN  = 16'h0f0f;
  localparam logic [15:0] MSK_MISC = 16'h0fc7;
  localparam logic [15:0] MSK_AUX  = 16'h0fff;
  localparam logic [15:0] MSK_PRD  = 16'h00ff;

  // ****************************************
  // field positions
  // ****************************************
  localparam int TAP_LSB     = 0;
  localparam int RANGE_LSB   = 8;
  localparam int DIR_LSB     = 0;
  localparam int LVL_LSB     = 8;
  localparam int RDY_SEL     = 0;
  localparam int RDY_POL     = 1;
  localparam int RDY_EN      = 2;
  localparam int ORIGIN_BIT  = 6;
  localparam int LINCOMP_BIT = 7;
  localparam int ST_POS_BIT  = 8;
  localparam int ST_NEG_BIT  = 9;
  localparam int SELF_BIT    = 10;
  localparam int MEM_BIT     = 11;
  localparam int TB_BIT      = 7;
  localparam int LATCH_BIT   = 2;

  // ****************************************
  // range codes and tap minimums
  // ****************************************
  localparam logic [2:0] RANGE_300 = 3'h4;
  localparam logic [2:0] RANGE_150 = 3'h2;
  localparam logic [2:0] RANGE_75  = 3'h1;
  localparam logic [2:0] TAP_MIN_150 = 3'h2;
  localparam logic [2:0] TAP_MIN_75  = 3'h4;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS      = 100;
  localparam int TB0_NS      = 610350;
  localparam int TB1_NS      = 18921000;
  localparam int TB0_CYC     = TB0_NS / CLK_NS;
  localparam int TB1_CYC     = TB1_NS / CLK_NS;
  localparam int RDY_MIN_US  = 100;
  localparam int RDY_MAX_US  = 200;
  localparam int RDY_CYC     = (RDY_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int MEMTEST_CYC = 2000;
  localparam int SELF_CYC    = 4000;

  typedef enum logic [1:0] {
    SIFC_T_IDLE = 2'b00,
    SIFC_T_MEM  = 2'b01,
    SIFC_T_SELF = 2'b10
  } sifc_test_t;

endpackage

// *** rtl/sifc_avg.sv ***
// Purpose : one running-average stage, 2^m taps, up to 128
// Assumes : clr pulses whenever m changes
// Notes   : history ramps in from zero after clr
`timescale 1ns/100ps
`default_nettype none
module sifc_avg (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic [2:0]  m,
  input  wire logic        in_valid,
  input  wire logic [15:0] in_data,
  output logic             out_valid,
  output logic [15:0]      out_data
);
  logic [15:0] mem_r   [128];
  logic [15:0] mem_nxt [128];
  logic [6:0]  wp_r,  wp_nxt;
  logic [22:0] sum_r, sum_nxt;
  logic        vld_r, vld_nxt;
  logic [6:0]  old_idx;
  logic [22:0] shifted;

  // ****************************************
  // window sum
  // ****************************************
  always_comb begin
    old_idx = wp_r - 7'((8'h01 << m));
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    sum_nxt = sum_r;
    vld_nxt = 1'b0;
    if (clr) begin
      for (int i = 0; i < 128; i++) begin
        mem_nxt[i] = 16'h0000;
      end
      wp_nxt  = 7'h00;
      sum_nxt = 23'h000000;
    end else if (in_valid) begin
      mem_nxt[wp_r] = in_data;
      sum_nxt = sum_r + {{7{in_data[15]}}, in_data} - {{7{mem_r[old_idx][15]}}, mem_r[old_idx]};
      wp_nxt  = wp_r + 7'h01;
      vld_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 128; i++) begin
        mem_r[i] <= 16'h0000;
      end
      wp_r  <= 7'h00;
      sum_r <= 23'h000000;
      vld_r <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      wp_r  <= wp_nxt;
      sum_r <= sum_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign shifted   = $signed(sum_r) >>> m;
  assign out_valid = vld_r;
  assign out_data  = shifted[15:0];
endmodule
`default_nettype wire

// *** rtl/sifc_top.sv ***
// Purpose : configuration, filtering, pins and converter latch of the sensor block
// Assumes : all inputs synchronous to clk; one command word per cmd_valid
// Notes   : read answer appears on rd_data one cycle after a read command
`timescale 1ns/100ps
`default_nettype none
module sifc_top #(
  parameter int TB0_CYC     = sifc_pkg::TB0_CYC,
  parameter int TB1_CYC     = sifc_pkg::TB1_CYC,
  parameter int MEMTEST_CYC = sifc_pkg::MEMTEST_CYC,
  parameter int SELF_CYC    = sifc_pkg::SELF_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic [15:0] cmd_word,
  output logic [15:0]      rd_data,
  output logic             rd_valid,
  input  wire logic        sens_valid,
  input  wire logic [15:0] sens_data,
  output logic [15:0]      filt_data,
  output logic             filt_valid,
  input  wire logic [3:0]  alarm_drive,
  input  wire logic [3:0]  alarm_level,
  input  wire logic [3:0]  pin_i,
  output logic [3:0]       pin_o,
  output logic [3:0]       pin_oe,
  output logic [2:0]       gyro_range,
  output logic             mem_test_run,
  output logic             self_test_run,
  output logic             stim_neg,
  output logic             stim_pos,
  output logic             lin_comp_en,
  output logic             origin_align_en,
  output logic [11:0]      aux_dac_code
);

  function automatic logic [15:0] put_byte(input logic [15:0] cur, input logic hi,
                                           input logic [7:0] d, input logic [15:0] msk);
    logic [15:0] v;
    v = hi ? {d, cur[7:0]} : {cur[15:8], d};
    put_byte = v & msk;
  endfunction

  function automatic logic [2:0] tap_floor(input logic [2:0] rng);
    tap_floor = (rng == sifc_pkg::RANGE_75)  ? sifc_pkg::TAP_MIN_75 :
                (rng == sifc_pkg::RANGE_150) ? sifc_pkg::TAP_MIN_150 : 3'h0;
  endfunction

  // ****************************************
  // registers and command decode
  // ****************************************
  logic [15:0] filt_r, filt_nxt;
  logic [15:0] pin_r,  pin_nxt;
  logic [15:0] misc_r, misc_nxt;
  logic [15:0] aux_r,  aux_nxt;
  logic [15:0] prd_r,  prd_nxt;
  logic [11:0] dac_r,  dac_nxt;
  logic [15:0] rd_r,   rd_nxt;
  logic        rdv_r,  rdv_nxt;
  logic        wr;
  logic [6:0]  badr;
  logic [7:0]  bdat;
  logic [2:0]  tap_m;
  logic [2:0]  rng;
  logic        mem_done, self_done;

  assign wr   = cmd_valid & cmd_word[15];
  assign badr = cmd_word[14:8];
  assign bdat = cmd_word[7:0];
  assign tap_m = filt_r[sifc_pkg::TAP_LSB +: 3];
  assign rng   = filt_r[sifc_pkg::RANGE_LSB +: 3];

  always_comb begin
    filt_nxt = filt_r;
    pin_nxt  = pin_r;
    misc_nxt = misc_r;
    aux_nxt  = aux_r;
    prd_nxt  = prd_r;
    dac_nxt  = dac_r;
    rd_nxt   = rd_r;
    rdv_nxt  = 1'b0;
    if (mem_done) begin
      misc_nxt[sifc_pkg::MEM_BIT] = 1'b0;
    end
    if (self_done) begin
      misc_nxt[sifc_pkg::SELF_BIT] = 1'b0;
    end
    if (wr) begin
      case (badr)
        sifc_pkg::ADDR_FILT_LO, sifc_pkg::ADDR_FILT_HI: begin
          filt_nxt = put_byte(filt_r, badr[0], bdat, sifc_pkg::MSK_FILT);
          if (filt_nxt[2:0] < tap_floor(filt_nxt[10:8])) begin
            filt_nxt[2:0] = tap_floor(filt_nxt[10:8]);
          end
        end
        sifc_pkg::ADDR_PIN_LO, sifc_pkg::ADDR_PIN_HI: begin
          pin_nxt = put_byte(pin_r, badr[0], bdat, sifc_pkg::MSK_PIN);
        end
        sifc_pkg::ADDR_MISC_LO, sifc_pkg::ADDR_MISC_HI: begin
          // start bit set wins over completion
          // merge into the cleared value so a low byte write keeps the clear
          misc_nxt = put_byte(misc_nxt, badr[0], bdat, sifc_pkg::MSK_MISC);
        end
        sifc_pkg::ADDR_AUX_LO, sifc_pkg::ADDR_AUX_HI: begin
          aux_nxt = put_byte(aux_r, badr[0], bdat, sifc_pkg::MSK_AUX);
        end
        sifc_pkg::ADDR_PRD_LO, sifc_pkg::ADDR_PRD_HI: begin
          prd_nxt = put_byte(prd_r, badr[0], bdat, sifc_pkg::MSK_PRD);
        end
        sifc_pkg::ADDR_GCMD_LO: begin
          if (bdat[sifc_pkg::LATCH_BIT]) begin
            dac_nxt = aux_r[11:0];
          end
        end
        default: begin
        end
      endcase
    end else if (cmd_valid) begin
      rdv_nxt = 1'b1;
      case ({badr[6:1], 1'b0})
        sifc_pkg::ADDR_FILT_LO: rd_nxt = filt_r;
        sifc_pkg::ADDR_PIN_LO:  rd_nxt = pin_r;
        sifc_pkg::ADDR_MISC_LO: rd_nxt = misc_r;
        sifc_pkg::ADDR_AUX_LO:  rd_nxt = aux_r;
        sifc_pkg::ADDR_PRD_LO:  rd_nxt = prd_r;
        default:                rd_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filt_r <= sifc_pkg::RST_FILT;
      pin_r  <= sifc_pkg::RST_PIN;
      // ready on pin one, active high
      misc_r <= sifc_pkg::RST_MISC;
      aux_r  <= sifc_pkg::RST_AUX;
      prd_r  <= sifc_pkg::RST_PRD;
      dac_r  <= 12'h000;
      rd_r   <= 16'h0000;
      rdv_r  <= 1'b0;
    end else begin
      filt_r <= filt_nxt;
      pin_r  <= pin_nxt;
      misc_r <= misc_nxt;
      aux_r  <= aux_nxt;
      prd_r  <= prd_nxt;
      dac_r  <= dac_nxt;
      rd_r   <= rd_nxt;
      rdv_r  <= rdv_nxt;
    end
  end

  // ****************************************
  // test routines
  // ****************************************
  sifc_pkg::sifc_test_t tst_r, tst_nxt;
  logic [15:0] tcnt_r, tcnt_nxt;

  always_comb begin
    tst_nxt   = tst_r;
    tcnt_nxt  = tcnt_r;
    mem_done  = 1'b0;
    self_done = 1'b0;
    case (tst_r)
      sifc_pkg::SIFC_T_IDLE: begin
        tcnt_nxt = 16'h0000;
        if (misc_r[sifc_pkg::MEM_BIT]) begin
          tst_nxt = sifc_pkg::SIFC_T_MEM;
        end else if (misc_r[sifc_pkg::SELF_BIT]) begin
          tst_nxt = sifc_pkg::SIFC_T_SELF;
        end
      end
      sifc_pkg::SIFC_T_MEM: begin
        tcnt_nxt = tcnt_r + 16'h0001;
        if (tcnt_r == 16'(MEMTEST_CYC - 1)) begin
          mem_done = 1'b1;
          tst_nxt  = sifc_pkg::SIFC_T_IDLE;
        end
      end
      sifc_pkg::SIFC_T_SELF: begin
        tcnt_nxt = tcnt_r + 16'h0001;
        if (tcnt_r == 16'(SELF_CYC - 1)) begin
          self_done = 1'b1;
          tst_nxt   = sifc_pkg::SIFC_T_IDLE;
        end
      end
      default: tst_nxt = sifc_pkg::SIFC_T_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tst_r  <= sifc_pkg::SIFC_T_IDLE;
      tcnt_r <= 16'h0000;
    end else begin
      tst_r  <= tst_nxt;
      tcnt_r <= tcnt_nxt;
    end
  end

  // ****************************************
  // sample timing
  // ****************************************
  logic [24:0] tb_r, tb_nxt;
  logic [6:0]  ns_r, ns_nxt;
  logic        p4_r, tick;
  logic        ext_clk;
  logic [24:0] tb_last;

  assign ext_clk = ~pin_r[sifc_pkg::DIR_LSB + 3] & (prd_r[7:0] == 8'h00);
  assign tb_last = prd_r[sifc_pkg::TB_BIT] ? 25'(TB1_CYC - 1) : 25'(TB0_CYC - 1);

  always_comb begin
    tb_nxt = tb_r;
    ns_nxt = ns_r;
    tick   = 1'b0;
    if (ext_clk) begin
      tb_nxt = 25'h0000000;
      ns_nxt = 7'h00;
      tick   = pin_i[3] & ~p4_r;
    end else if (tb_r >= tb_last) begin
      tb_nxt = 25'h0000000;
      if (ns_r >= prd_r[6:0]) begin
        ns_nxt = 7'h00;
        tick   = 1'b1;
      end else begin
        ns_nxt = ns_r + 7'h01;
      end
    end else begin
      tb_nxt = tb_r + 25'h0000001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tb_r <= 25'h0000000;
      ns_r <= 7'h00;
      p4_r <= 1'b0;
    end else begin
      tb_r <= tb_nxt;
      ns_r <= ns_nxt;
      p4_r <= pin_i[3];
    end
  end

  // ****************************************
  // two-stage averaging filter
  // ****************************************
  logic [15:0] smp_r, s1_data, s2_data;
  logic        smp_v_r, s1_valid, s2_valid;
  logic [2:0]  m_prev_r;
  logic        m_chg;

  assign m_chg = (m_prev_r != tap_m);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smp_r    <= 16'h0000;
      smp_v_r  <= 1'b0;
      m_prev_r <= sifc_pkg::RST_FILT[2:0];
    end else begin
      if (sens_valid) begin
        smp_r <= sens_data;
      end
      smp_v_r  <= tick;
      m_prev_r <= tap_m;
    end
  end

  sifc_avg u_stage1 (
    .clk       (clk),
    .rst_n     (rst_n),
    .clr       (m_chg),
    .m         (tap_m),
    .in_valid  (smp_v_r),
    .in_data   (smp_r),
    .out_valid (s1_valid),
    .out_data  (s1_data)
  );

  sifc_avg u_stage2 (
    .clk       (clk),
    .rst_n     (rst_n),
    .clr       (m_chg),
    .m         (tap_m),
    .in_valid  (s1_valid),
    .in_data   (s1_data),
    .out_valid (s2_valid),
    .out_data  (s2_data)
  );

  // ****************************************
  // data ready pulse and pin mux
  // ****************************************
  logic [10:0] rdy_r, rdy_nxt;
  logic [3:0]  po_r, po_nxt, poe_r, poe_nxt;
  logic [15:0] fo_r;
  logic        fv_r;
  logic        rdy_on;
  logic        rdy_en;

  assign rdy_en = misc_r[sifc_pkg::RDY_EN];
  assign rdy_on = (rdy_r != 11'h000);

  always_comb begin
    rdy_nxt = rdy_r;
    if (s2_valid && rdy_en) begin
      rdy_nxt = 11'(sifc_pkg::RDY_CYC);
    end else if (rdy_on) begin
      rdy_nxt = rdy_r - 11'h001;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      poe_nxt[i] = pin_r[sifc_pkg::DIR_LSB + i];
      po_nxt[i]  = pin_r[sifc_pkg::LVL_LSB + i];
      if (alarm_drive[i]) begin
        poe_nxt[i] = 1'b1;
        po_nxt[i]  = alarm_level[i];
      end
    end
    if (rdy_en) begin
      poe_nxt[{1'b0, misc_r[sifc_pkg::RDY_SEL]}] = 1'b1;
      po_nxt[{1'b0, misc_r[sifc_pkg::RDY_SEL]}]  = ~(rdy_on ^ misc_r[sifc_pkg::RDY_POL]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdy_r <= 11'h000;
      po_r  <= 4'h0;
      poe_r <= 4'h0;
      fo_r  <= 16'h0000;
      fv_r  <= 1'b0;
    end else begin
      rdy_r <= rdy_nxt;
      po_r  <= po_nxt;
      poe_r <= poe_nxt;
      fo_r  <= s2_valid ? s2_data : fo_r;
      fv_r  <= s2_valid;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rd_data         = rd_r;
  assign rd_valid        = rdv_r;
  assign filt_data       = fo_r;
  assign filt_valid      = fv_r;
  assign pin_o           = po_r;
  assign pin_oe          = poe_r;
  assign gyro_range      = rng;
  assign mem_test_run    = misc_r[sifc_pkg::MEM_BIT];
  assign self_test_run   = misc_r[sifc_pkg::SELF_BIT];
  assign stim_neg        = misc_r[sifc_pkg::ST_NEG_BIT];
  assign stim_pos        = misc_r[sifc_pkg::ST_POS_BIT];
  assign lin_comp_en     = misc_r[sifc_pkg::LINCOMP_BIT];
  assign origin_align_en = misc_r[sifc_pkg::ORIGIN_BIT];
  assign aux_dac_code    = dac_r;

endmodule
`default_nettype wire

// *** sim/sifc_host.sv ***
// Purpose : host model issuing command words
// Assumes : one word per cmd_valid pulse
// Notes   : released word shows its inverse
`timescale 1ns/100ps
`default_nettype none
module sifc_host (
  input  wire logic  clk,
  output logic       cmd_valid,
  output logic [15:0] cmd_word
);
  initial begin
    cmd_valid = 1'b0;
    cmd_word  = 16'h0000;
  end
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_word  <= w;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_word  <= ~w;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    send({1'b1, a, d});
  endtask
  task automatic rd(input logic [6:0] a);
    send({1'b0, a, 8'h00});
  endtask
endmodule
`default_nettype wire

// *** sim/sifc_top_checker.sv ***
// Purpose : port assertions for sifc_top
// Assumes : one clock, synchronous active-low reset
// Notes   : bound into every sifc_top instance
`timescale 1ns/100ps
`default_nettype none
module sifc_top_checker #(
  parameter int MEMTEST_CYC = 10,
  parameter int SELF_CYC    = 10
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic [3:0]  alarm_drive,
  input wire logic [3:0]  alarm_level,
  input wire logic [3:0]  pin_o,
  input wire logic [3:0]  pin_oe,
  input wire logic [2:0]  gyro_range,
  input wire logic        mem_test_run,
  input wire logic        self_test_run,
  input wire logic        stim_neg,
  input wire logic        stim_pos,
  input wire logic        lin_comp_en,
  input wire logic        origin_align_en,
  input wire logic [11:0] aux_dac_code
);
  // ****************************************
  // assertions
  // ****************************************
  localparam int TEST_MAX = MEMTEST_CYC + SELF_CYC + 4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic w_rng = cmd_valid && cmd_word[15:8] == 8'hb9;
  wire logic w_mlo = cmd_valid && cmd_word[15:8] == 8'hb4;
  wire logic w_mhi = cmd_valid && cmd_word[15:8] == 8'hb5;
  wire logic w_lat = cmd_valid && cmd_word[15:8] == 8'hbe && cmd_word[2];
  range_reset_a: assert property (disable iff (1'b0) !rst_n |=> gyro_range == 3'h4)
    else $error("range not default after reset");
  range_write_a: assert property (w_rng && cmd_word[2:0] inside {3'h1, 3'h2, 3'h4}
    |=> gyro_range == $past(cmd_word[2:0])) else $error("range not taken");
  ready_idle_a: assert property ($rose(rst_n) |-> ##[1:2] (pin_oe[0] && !pin_o[0]))
    else $error("ready pin not idle high-active");
  mem_clear_a: assert property ($rose(mem_test_run) |-> ##[1:TEST_MAX] !mem_test_run)
    else $error("memory test bit stuck");
  self_start_a: assert property ($rose(self_test_run) |-> $past(w_mhi && cmd_word[2]))
    else $error("self test started unasked");
  stim_follow_a: assert property (w_mhi ##1 !w_mhi |=>
    stim_neg == $past(cmd_word[1], 2) && stim_pos == $past(cmd_word[0], 2))
    else $error("stimulus bits wrong");
  comp_follow_a: assert property (w_mlo ##1 !w_mlo |=>
    lin_comp_en == $past(cmd_word[7], 2) && origin_align_en == $past(cmd_word[6], 2))
    else $error("compensation bits wrong");
  dac_hold_a: assert property ($changed(aux_dac_code) |-> $past(w_lat))
    else $error("converter moved without latch");
  alarm_wins_a: assert property (alarm_drive[3] |=>
    pin_oe[3] && pin_o[3] == $past(alarm_level[3])) else $error("alarm lost pin four");
  cover property (w_lat);
  cover property ($fell(self_test_run));
  cover property ($rose(pin_o[0]));
endmodule
bind sifc_top sifc_top_checker #(.MEMTEST_CYC(MEMTEST_CYC), .SELF_CYC(SELF_CYC)) chk_inst (
  .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
  .alarm_drive(alarm_drive), .alarm_level(alarm_level), .pin_o(pin_o), .pin_oe(pin_oe),
  .gyro_range(gyro_range), .mem_test_run(mem_test_run), .self_test_run(self_test_run),
  .stim_neg(stim_neg), .stim_pos(stim_pos), .lin_comp_en(lin_comp_en),
  .origin_align_en(origin_align_en), .aux_dac_code(aux_dac_code));
`default_nettype wire

// *** sim/tb_sifc_top.sv ***
// Purpose : self-checking bench for sifc_top
// Assumes : shortened counts 4, 8, 10, 10
// Notes   : read answers checked from a queue
`timescale 1ns/100ps
`default_nettype none
module tb_sifc_top;
  logic        clk, rst_n, cmd_valid, rd_valid, sens_valid, filt_valid, rnd_on;
  logic [15:0] cmd_word, rd_data, sens_data, filt_data;
  logic [3:0]  alarm_drive, alarm_level, pin_i, pin_o, pin_oe, lv, al;
  logic [2:0]  gyro_range, m, e;
  logic        mem_test_run, self_test_run, stim_neg, stim_pos, lin_comp_en, origin_align_en;
  logic [11:0] aux_dac_code;
  logic [15:0] expq[$];
  int          miscompares, checks_done, fv_cnt, c0, n;
  logic [6:0]  ra[5] = '{7'h38, 7'h32, 7'h34, 7'h30, 7'h3c};
  logic [15:0] rv[5] = '{16'h0402, 16'h0000, 16'h0006, 16'h0000, 16'h0000};
  logic [2:0]  rc[3] = '{3'h2, 3'h1, 3'h4};
  logic [2:0]  mn[3] = '{3'h2, 3'h4, 3'h0};
  sifc_host sifc_host_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
  sifc_top #(.TB0_CYC(4), .TB1_CYC(8), .MEMTEST_CYC(10), .SELF_CYC(10)) sifc_top_inst (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .rd_data(rd_data), .rd_valid(rd_valid), .sens_valid(sens_valid),
    .sens_data(sens_data), .filt_data(filt_data), .filt_valid(filt_valid),
    .alarm_drive(alarm_drive), .alarm_level(alarm_level), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe), .gyro_range(gyro_range), .mem_test_run(mem_test_run),
    .self_test_run(self_test_run), .stim_neg(stim_neg), .stim_pos(stim_pos),
    .lin_comp_en(lin_comp_en), .origin_align_en(origin_align_en),
    .aux_dac_code(aux_dac_code));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************************************
  // checking
  // ****************************************
  task automatic tally_and_finish();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic guard(input int k, input int lim);
    if (k >= lim) begin
      chk(16'(k), 16'(lim - 1));
      tally_and_finish();
    end
  endtask
  task automatic rdx(input logic [6:0] a, input logic [15:0] exp);
    expq.push_back(exp);
    sifc_host_inst.rd(a);
  endtask
  task automatic pulse_w(input int p, input logic act);
    n = 0;
    while (pin_o[p] === act && n < 3000) begin @(posedge clk); n++; end
    guard(n, 3000);
    n = 0;
    while (pin_o[p] !== act && n < 3000) begin @(posedge clk); n++; end
    guard(n, 3000);
    n = 0;
    while (pin_o[p] === act && n < 3000) begin @(posedge clk); n++; end
    chk(16'(n >= 1000 && n <= 2000), 16'h0001);
  endtask
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (expq.size() == 0) chk(rd_data, ~rd_data);
      else chk(rd_data, expq.pop_front());
    end
    if (filt_valid === 1'b1) fv_cnt <= fv_cnt + 1;
    sens_data <= rnd_on ? 16'($urandom) : 16'h0100;
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    rst_n = 1'b0; sens_valid = 1'b0; sens_data = 16'h0000; rnd_on = 1'b0;
    alarm_drive = 4'h0; alarm_level = 4'h0; pin_i = 4'h0;
    miscompares = 0; checks_done = 0; fv_cnt = 0;
    n = $urandom(32'h11f614da);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1; sens_valid <= 1'b1; rnd_on <= 1'b1;
    foreach (ra[i]) rdx(ra[i], rv[i]);
    for (int i = 0; i < 3; i++) begin
      sifc_host_inst.wr(7'h39, {5'h1f, rc[i]});
      m = (i == 0) ? 3'h0 : 3'($urandom % (i == 1 ? 4 : 8));
      sifc_host_inst.wr(7'h38, {5'h1f, m});
      e = (m < mn[i]) ? mn[i] : m;
      rdx(7'h38, {5'h00, rc[i], 5'h00, e});
      chk(16'(gyro_range), 16'(rc[i]));
    end
    sifc_host_inst.wr(7'h38, 8'h04);
    rdx(7'h38, 16'h0404);
    sifc_host_inst.wr(7'h35, 8'h03);
    sifc_host_inst.wr(7'h34, 8'hc6);
    repeat (2) @(posedge clk);
    chk({12'h000, stim_neg, stim_pos, lin_comp_en, origin_align_en}, 16'h000f);
    rdx(7'h34, 16'h03c6);
    sifc_host_inst.wr(7'h35, 8'h0c);
    @(posedge clk);
    chk(16'({mem_test_run, self_test_run}), 16'h0003);
    n = 0;
    while ((mem_test_run | self_test_run) !== 1'b0 && n < 100) begin @(posedge clk); n++; end
    guard(n, 100);
    rdx(7'h34, 16'h00c6);
    sifc_host_inst.wr(7'h30, 8'hd9);
    sifc_host_inst.wr(7'h31, 8'hf4);
    repeat (2) @(posedge clk);
    chk(16'(aux_dac_code), 16'h0000);
    rdx(7'h30, 16'h04d9);
    sifc_host_inst.wr(7'h3e, 8'h04);
    repeat (2) @(posedge clk);
    chk(16'(aux_dac_code), 16'h04d9);
    lv = 4'($urandom);
    al = ~lv;
    sifc_host_inst.wr(7'h33, {4'h0, lv});
    sifc_host_inst.wr(7'h32, 8'h0f);
    repeat (2) @(posedge clk);
    chk(16'({pin_oe, pin_o[3:1]}), 16'({4'hf, lv[3:1]}));
    alarm_drive <= 4'h8;
    alarm_level <= al;
    repeat (2) @(posedge clk);
    chk(16'(pin_o[3]), 16'(al[3]));
    alarm_drive <= 4'h0;
    sifc_host_inst.wr(7'h34, 8'hc2);
    repeat (2) @(posedge clk);
    chk(16'({pin_oe[0], pin_o[0]}), 16'({1'b1, lv[0]}));
    rnd_on <= 1'b0;
    sifc_host_inst.wr(7'h32, 8'h00);
    sifc_host_inst.wr(7'h36, 8'h00);
    sifc_host_inst.wr(7'h38, 8'h01);
    repeat (20) @(posedge clk);
    c0 = fv_cnt;
    repeat (8) begin
      repeat (10) @(posedge clk);
      pin_i[3] <= 1'b1;
      repeat (10) @(posedge clk);
      pin_i[3] <= 1'b0;
    end
    repeat (10) @(posedge clk);
    chk(16'(fv_cnt - c0), 16'h0008);
    chk(filt_data, 16'h0100);
    sifc_host_inst.wr(7'h36, 8'hff);
    sifc_host_inst.wr(7'h34, 8'h06);
    pulse_w(0, 1'b1);
    sifc_host_inst.wr(7'h34, 8'h05);
    pulse_w(1, 1'b0);
    chk(16'(pin_oe[1]), 16'h0001);
    repeat (5) @(posedge clk);
    chk(16'(expq.size()), 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
